// file: hw/crs_pkg.sv
package crs_pkg;

    // ========================================================================
    // register map (byte addresses, one aligned word each)
    // ========================================================================
    localparam logic [7:0] ADDR_INSTR_PTR   = 8'h00;
    localparam logic [7:0] ADDR_ACC         = 8'h04;
    localparam logic [7:0] ADDR_TMP_ACC     = 8'h08;
    localparam logic [7:0] ADDR_INDEX_PTR   = 8'h0c;
    localparam logic [7:0] ADDR_MEM_PTR     = 8'h10;
    localparam logic [7:0] ADDR_STACK_PTR   = 8'h14;
    localparam logic [7:0] ADDR_PSW         = 8'h18;
    localparam logic [7:0] ADDR_BANK_ONLY   = 8'h1c;
    localparam logic [7:0] ADDR_ALU_CMD     = 8'h20;
    localparam logic [7:0] ADDR_GPR_ADDR    = 8'h24;
    localparam logic [7:0] ADDR_MAP_CHECK   = 8'h28;

    // ========================================================================
    // condition flag field positions (low byte of status word)
    // ========================================================================
    localparam int FLAG_HALF    = 7;
    localparam int FLAG_IRQ_EN  = 6;
    localparam int FLAG_LVL_HI  = 5;
    localparam int FLAG_LVL_LO  = 4;
    localparam int FLAG_NEG     = 3;
    localparam int FLAG_ZERO    = 2;
    localparam int FLAG_OVF     = 1;
    localparam int FLAG_CARRY   = 0;

    // ========================================================================
    // reset values
    // ========================================================================
    localparam logic [15:0] RST_WORD    = 16'h0000;
    localparam logic [15:0] RST_PSW     = 16'h0030;  // irq off, level 3
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ========================================================================
    // memory map
    // ========================================================================
    localparam logic [15:0] IO_TOP       = 16'h007f;
    localparam logic [15:0] EXT_BANK_LO  = 16'h0180;
    localparam logic [15:0] EXT_BANK_HI  = 16'h01ff;
    localparam logic [15:0] OPT_AREA_LO  = 16'h8000;
    localparam logic [15:0] OPT_AREA_HI  = 16'h8005;
    localparam logic [15:0] PROG_BASE    = 16'h8000;
    localparam logic [6:0]  GPR_HIGH     = 7'h00;

    // ========================================================================
    // alu operations
    // ========================================================================
    typedef enum logic [2:0] {
        CRS_OP_ADD = 3'h0,
        CRS_OP_SUB = 3'h1,
        CRS_OP_SHL = 3'h2,
        CRS_OP_SHR = 3'h3,
        CRS_OP_AND = 3'h4,
        CRS_OP_OR  = 3'h5,
        CRS_OP_XOR = 3'h6,
        CRS_OP_MOV = 3'h7
    } crs_op_e;

    // memory region codes returned by the map checker
    typedef enum logic [2:0] {
        CRS_REG_IO    = 3'h0,
        CRS_REG_DATA  = 3'h1,
        CRS_REG_EXTGR = 3'h2,
        CRS_REG_OPT   = 3'h3,
        CRS_REG_PROG  = 3'h4
    } crs_region_e;

endpackage

// file: hw/crs_alu.sv
module crs_alu
    import crs_pkg::*;
(
    input  wire logic [2:0]  op,
    input  wire logic        wide,
    input  wire logic [15:0] a_in,
    input  wire logic [15:0] b_in,
    input  wire logic [7:0]  flags_in,
    output logic      [15:0] res,
    output logic      [7:0]  flags_out
);

    logic [16:0] sum;
    logic [4:0]  nib;
    logic        msb;
    logic        cout;
    logic        ovf;

    // ========================================================================
    // result and flag computation, byte or word wide
    // ========================================================================
    always_comb begin
        sum  = 17'h00000;
        nib  = 5'h00;
        cout = flags_in[FLAG_CARRY];
        ovf  = 1'b0;
        res  = a_in;
        unique case (crs_op_e'(op))
            CRS_OP_ADD: begin
                sum = {1'b0, a_in} + {1'b0, b_in};
                nib = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
                res = sum[15:0];
                ovf = wide ? (a_in[15] == b_in[15]) && (res[15] != a_in[15])
                           : (a_in[7] == b_in[7]) && (res[7] != a_in[7]);
                cout = wide ? sum[16] : (a_in[7:0] + {1'b0,b_in[7:0]}) > 9'hff
                    ? 1'b1 : 1'b0;
            end
            CRS_OP_SUB: begin
                sum = {1'b0, a_in} - {1'b0, b_in};
                nib = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]};
                res = sum[15:0];
                ovf = wide ? (a_in[15] != b_in[15]) && (res[15] != a_in[15])
                           : (a_in[7] != b_in[7]) && (res[7] != a_in[7]);
                cout = wide ? (b_in > a_in) : (b_in[7:0] > a_in[7:0]);
            end
            CRS_OP_SHL: begin
                res  = {a_in[14:0], 1'b0};
                cout = wide ? a_in[15] : a_in[7];
            end
            CRS_OP_SHR: begin
                res  = wide ? {1'b0, a_in[15:1]} : {8'h00, 1'b0, a_in[7:1]};
                cout = a_in[0];
            end
            CRS_OP_AND: res = a_in & b_in;
            CRS_OP_OR:  res = a_in | b_in;
            CRS_OP_XOR: res = a_in ^ b_in;
            default:    res = b_in;
        endcase
        if (!wide) begin
            res = {8'h00, res[7:0]};
        end
        msb = wide ? res[15] : res[7];
        flags_out = flags_in;
        flags_out[FLAG_HALF]  = nib[4];
        flags_out[FLAG_NEG]   = msb;
        flags_out[FLAG_ZERO]  = (res == 16'h0000);
        flags_out[FLAG_OVF]   = ovf;
        flags_out[FLAG_CARRY] = cout;
    end

endmodule

// file: hw/crs_map.sv
module crs_map
    import crs_pkg::*;
(
    input  wire logic [15:0] addr,
    input  wire logic        small_ram,
    output logic      [2:0]  region
);

    // ========================================================================
    // classify an address in the 64 kbyte space
    // ========================================================================
    always_comb begin
        if (addr <= IO_TOP) begin
            region = CRS_REG_IO;
        end else if (small_ram && addr >= EXT_BANK_LO
                     && addr <= EXT_BANK_HI) begin
            region = CRS_REG_EXTGR;
        end else if (addr >= OPT_AREA_LO && addr <= OPT_AREA_HI) begin
            region = CRS_REG_OPT;
        end else if (addr >= PROG_BASE) begin
            region = CRS_REG_PROG;
        end else begin
            region = CRS_REG_DATA;
        end
    end

endmodule

// file: hw/crs_core_regs.sv
module crs_core_regs
    import crs_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // core side
    input  wire logic        small_ram,
    input  wire logic [1:0]  irq_req_level,
    input  wire logic        irq_req,
    output logic             irq_take_r,
    output logic      [15:0] gpr_addr_r,
    output logic             gpr_ext_r
);

    // ========================================================================
    // dedicated registers
    // ========================================================================
    logic [15:0] instruction_pointer_r;
    logic [15:0] acc_r;
    logic [15:0] tmp_acc_r;
    logic [15:0] index_pointer_r;
    logic [15:0] memory_pointer_r;
    logic [15:0] stack_top_pointer_r;
    logic [7:0]  bank_select_pointer_r;
    logic [7:0]  condition_flags_r;
    logic [2:0]  gpr_sel_r;
    logic [15:0] map_addr_r;

    // ========================================================================
    // bus handshake state
    // ========================================================================
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        wr_fire;
    logic        wr_hit;

    // ========================================================================
    // alu and map helpers
    // ========================================================================
    logic [15:0] alu_res;
    logic [7:0]  alu_flags;
    logic [2:0]  alu_op;
    logic        alu_wide;
    logic [2:0]  region;

    // byte-lane merge so partial writes keep the untouched lanes
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = old;
        if (s[0]) begin
            merge16[7:0] = d[7:0];
        end
        if (s[1]) begin
            merge16[15:8] = d[15:8];
        end
    endfunction

    // general register address from bank pointer and opcode bits
    function automatic logic [15:0] gpr_addr(input logic [4:0] bank,
                                             input logic [2:0] sel);
        gpr_addr = {GPR_HIGH, 1'b1, bank, sel};
    endfunction

    // priority compare: smaller code is higher priority, 3 lowest
    function automatic logic lvl_higher(input logic [1:0] req,
                                        input logic [1:0] allowed);
        lvl_higher = (req < allowed);
    endfunction

    // alu command written at ADDR_ALU_CMD: op in [2:0], wide in [3]
    assign alu_op   = w_data_r[2:0];
    assign alu_wide = w_data_r[3];

    crs_alu u_alu (
        .op        (alu_op),
        .wide      (alu_wide),
        .a_in      (acc_r),
        .b_in      (tmp_acc_r),
        .flags_in  (condition_flags_r),
        .res       (alu_res),
        .flags_out (alu_flags)
    );

    crs_map u_map (
        .addr      (map_addr_r),
        .small_ram (small_ram),
        .region    (region)
    );

    // a write completes once both address and data have been captured
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_hit  = (aw_addr_r <= ADDR_MAP_CHECK) && (aw_addr_r[1:0] == 2'h0);

    // ========================================================================
    // write address and data channels, taken in either order
    // ========================================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
            end
        end
    end

    // write response, one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ========================================================================
    // pointer and accumulator registers
    // ========================================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instruction_pointer_r <= RST_WORD;
            acc_r                 <= RST_WORD;
            tmp_acc_r             <= RST_WORD;
            index_pointer_r       <= RST_WORD;
            memory_pointer_r      <= RST_WORD;
            stack_top_pointer_r   <= RST_WORD;
            map_addr_r            <= RST_WORD;
        end else if (wr_fire && wr_hit) begin
            unique case (aw_addr_r)
                ADDR_INSTR_PTR: instruction_pointer_r <=
                    merge16(instruction_pointer_r, w_data_r, w_strb_r);
                ADDR_ACC: acc_r <= merge16(acc_r, w_data_r, w_strb_r);
                ADDR_TMP_ACC: tmp_acc_r <=
                    merge16(tmp_acc_r, w_data_r, w_strb_r);
                ADDR_INDEX_PTR: index_pointer_r <=
                    merge16(index_pointer_r, w_data_r, w_strb_r);
                ADDR_MEM_PTR: memory_pointer_r <=
                    merge16(memory_pointer_r, w_data_r, w_strb_r);
                ADDR_STACK_PTR: stack_top_pointer_r <=
                    merge16(stack_top_pointer_r, w_data_r, w_strb_r);
                ADDR_ALU_CMD: acc_r <= alu_res;
                ADDR_MAP_CHECK: map_addr_r <=
                    merge16(map_addr_r, w_data_r, w_strb_r);
                default: ;
            endcase
        end
    end

    // ========================================================================
    // status word: bank pointer half and flag half written separately
    // ========================================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bank_select_pointer_r <= RST_PSW[15:8];
            condition_flags_r     <= RST_PSW[7:0];
            gpr_sel_r             <= 3'h0;
        end else if (wr_fire && wr_hit) begin
            unique case (aw_addr_r)
                ADDR_PSW: begin
                    if (w_strb_r[1]) begin
                        bank_select_pointer_r <= w_data_r[15:8];
                    end
                    if (w_strb_r[0]) begin
                        condition_flags_r <= w_data_r[7:0];
                    end
                end
                ADDR_BANK_ONLY: if (w_strb_r[0]) begin
                    bank_select_pointer_r <= w_data_r[7:0];
                end
                ADDR_ALU_CMD: condition_flags_r <= alu_flags;
                ADDR_GPR_ADDR: if (w_strb_r[0]) begin
                    gpr_sel_r <= w_data_r[2:0];
                end
                default: ;
            endcase
        end
    end

    // ========================================================================
    // general register address and external bank indication
    // ========================================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gpr_addr_r <= 16'h0100;
            gpr_ext_r  <= 1'b0;
        end else begin
            // bank field is 5 bits: 32 banks of 8 registers
            gpr_addr_r <= gpr_addr(bank_select_pointer_r[4:0],
                                   gpr_sel_r);
            // upper 16 banks land in external ram on the small variant
            gpr_ext_r  <= small_ram && bank_select_pointer_r[4];
        end
    end

    // ========================================================================
    // interrupt acceptance gate
    // ========================================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_take_r <= 1'b0;
        end else begin
            irq_take_r <= irq_req && condition_flags_r[FLAG_IRQ_EN]
                && lvl_higher(irq_req_level,
                    condition_flags_r[FLAG_LVL_HI:FLAG_LVL_LO]);
        end
    end

    // ========================================================================
    // read channel: one read in flight, answer two cycles after address
    // ========================================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                unique case (s_axi_araddr)
                    ADDR_INSTR_PTR: s_axi_rdata <= {16'h0000,
                        instruction_pointer_r};
                    ADDR_ACC:       s_axi_rdata <= {16'h0000, acc_r};
                    ADDR_TMP_ACC:   s_axi_rdata <= {16'h0000, tmp_acc_r};
                    ADDR_INDEX_PTR: s_axi_rdata <= {16'h0000, index_pointer_r};
                    ADDR_MEM_PTR:   s_axi_rdata <= {16'h0000, memory_pointer_r};
                    ADDR_STACK_PTR: s_axi_rdata <= {16'h0000,
                        stack_top_pointer_r};
                    ADDR_PSW: s_axi_rdata <= {16'h0000,
                        bank_select_pointer_r, condition_flags_r};
                    ADDR_BANK_ONLY: s_axi_rdata <= {24'h000000,
                        bank_select_pointer_r};
                    ADDR_ALU_CMD:   s_axi_rdata <= 32'h0000_0000;
                    ADDR_GPR_ADDR:  s_axi_rdata <= {15'h0000, gpr_ext_r,
                        gpr_addr_r};
                    ADDR_MAP_CHECK: s_axi_rdata <= {13'h0000, region,
                        map_addr_r};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// file: verification/crs_props.sv
module crs_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        small_ram,
    input wire logic        irq_req,
    input wire logic [1:0]  irq_req_level,
    input wire logic        irq_take_r,
    input wire logic [15:0] gpr_addr_r,
    input wire logic        gpr_ext_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ========================================================================
    // register bus timing
    AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held past one cycle");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready
        |-> ##[1:4] s_axi_bvalid) else $error("write response missing");
    AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("write response repeated");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read data late");
    AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("read data repeated");
    // ========================================================================
    // core side outputs; level 3 is the lowest and can never win
    AST_GPR_FORM: assert property (gpr_addr_r[15:8] == 8'h01)
        else $error("register address high byte wrong");
    AST_GPR_EXT: assert property (gpr_ext_r ==
        ($past(small_ram) && gpr_addr_r[7])) else $error("external bank flag");
    AST_IRQ_LVL: assert property (irq_take_r |-> $past(irq_req) &&
        $past(irq_req_level) != 2'h3) else $error("irq taken wrongly");
    AST_IRQ_RST: assert property ($past(aresetn) == 1'b0
        |-> !irq_take_r) else $error("irq taken after reset");
    cover property (irq_take_r);
    cover property (gpr_ext_r);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind crs_core_regs crs_props u_props (.*);

// file: verification/test_cpu_core_register_set.sv
module test_cpu_core_register_set import crs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, small_ram;
    logic        irq_req, irq_take_r, gpr_ext_r, c, h, v;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, m;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, irq_req_level;
    logic [15:0] gpr_addr_r, a, b, r;
    logic [16:0] s;
    int          p;
    logic [65:0] q;
    logic [65:0] rq[$];
    logic [1:0]  bq[$];
    logic [15:0] mad[5] = '{16'h0050, 16'h0100, 16'h0180, 16'h8003, 16'hc000};
    int          fail_count = 0;
    int          check_count = 0;
    crs_core_regs uut (.*);
    // ========================================================================
    // clock, watchdog and verdict
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // generous bound: the whole run needs under a thousand cycles
    initial begin
        #100us;
        fail_count++;
        print_verdict();
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // ========================================================================
    // bus master; expectations queued, answers judged by the monitor
    task automatic wr(logic [7:0] ad, logic [31:0] dd, logic [1:0] rs = 2'h0);
        bit aw = 0;
        bit w = 0;
        bq.push_back(rs);
        @(posedge aclk);
        s_axi_awaddr  <= ad;
        s_axi_wdata   <= dd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_axi_awready) aw = 1;
            if (s_axi_wready) w = 1;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(logic [7:0] ad, logic [31:0] e, logic [31:0] mk = '1,
                      logic [1:0] rs = 2'h0);
        rq.push_back({mk, rs, e & mk});
        @(posedge aclk);
        s_axi_araddr  <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    // monitor: pairs each response with the oldest queued note
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            q = rq.pop_front();
            chk("rdata", q[31:0], s_axi_rdata & q[65:34]);
            chk("rresp", {30'h0, q[33:32]}, {30'h0, s_axi_rresp});
        end
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
    end
    // ========================================================================
    // main sequence
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
         small_ram, irq_req, irq_req_level, s_axi_awaddr, s_axi_araddr,
         s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        aresetn = 1'b0;
        void'($urandom(75));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) rd(8'(i * 4), 0);
        rd(ADDR_PSW, {16'h0, RST_PSW});
        rd(ADDR_GPR_ADDR, 32'h100);
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            d = $urandom;
            wr(8'(i * 4), d);
            rd(8'(i * 4), {16'h0, d[15:0]});
        end
        $display("test pointer registers done");
        for (int i = 0; i < 6; i++) begin
            d = $urandom;
            small_ram <= d[20];
            wr(ADDR_PSW, {16'h0, d[15:8], 8'h30});
            wr(ADDR_BANK_ONLY, {24'h0, d[31:24]});
            wr(ADDR_GPR_ADDR, {29'h0, d[18:16]});
            rd(ADDR_PSW, {16'h0, d[31:24], 8'h30});
            rd(ADDR_GPR_ADDR, {15'h0, d[20] & d[28], 8'h01, d[28:24],
                d[18:16]});
            chk("gpr_addr", {24'h1, d[28:24], d[18:16]}, gpr_addr_r);
        end
        $display("test bank mapping done");
        for (int i = 0; i < 16; i++) begin
            d = $urandom;
            // second half of the loop runs word wide with full operands
            p = i[3] ? 15 : 7;
            a = i[3] ? d[15:0] : {8'h0, d[7:0]};
            b = i[3] ? d[31:16] : {8'h0, d[15:8]};
            wr(ADDR_ACC, {16'h0, a});
            wr(ADDR_TMP_ACC, {16'h0, b});
            wr(ADDR_ALU_CMD, {28'h0, i[3:0]});
            case (i % 8)
                0: s = {1'b0, a} + b;
                1: s = {1'b0, a} - b;
                2: s = {a, 1'b0};
                3: s = {2'h0, a[15:1]};
                4: s = {1'b0, a & b};
                5: s = {1'b0, a | b};
                6: s = {1'b0, a ^ b};
                default: s = {1'b0, b};
            endcase
            r = i[3] ? s[15:0] : {8'h0, s[7:0]};
            c = (i % 8 == 3) ? a[0] : s[p + 1];
            h = (i % 8 == 0) ? ({1'b0, a[3:0]} + b[3:0] > 5'h0f)
                             : a[3:0] < b[3:0];
            v = (a[p] ^ r[p]) & ((i % 8 == 0) ? a[p] ~^ b[p] : a[p] ^ b[p]);
            m = (i % 8 < 2) ? 32'hff : (i % 8 < 4) ? 32'h01 : 32'h0;
            rd(ADDR_ACC, {16'h0, r});
            rd(ADDR_PSW, {24'h0, h, 3'h3, r[p], r == 0, v, c}, m);
        end
        $display("test alu flags done");
        for (int i = 0; i < 20; i++) begin
            irq_req       <= i != 4;
            irq_req_level <= i[1:0];
            wr(ADDR_PSW, {24'h0, 1'b0, i < 16, i[3:2], 4'h0});
            repeat (2) @(posedge aclk);
            chk("irq_take", {31'h0, i != 4 && i < 16 && i[1:0] < i[3:2]},
                {31'h0, irq_take_r});
        end
        $display("test interrupt level done");
        rd(8'h2c, 0, 0, RESP_SLVERR);
        wr(8'h2c, 32'h1, RESP_SLVERR);
        rd(8'h06, 0, 0, RESP_SLVERR);
        // partial strobe: only lane 1 lands, lanes 2 and 3 are ignored
        wr(ADDR_MEM_PTR, 32'h1234);
        s_axi_wstrb <= 4'he;
        wr(ADDR_MEM_PTR, 32'hcdab_ef56);
        s_axi_wstrb <= 4'hf;
        rd(ADDR_MEM_PTR, 32'hef34);
        small_ram <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_MAP_CHECK, {16'h0, mad[i]});
            rd(ADDR_MAP_CHECK, i << 16, 32'h70000);
        end
        $display("test errors and map done");
        print_verdict();
    end
endmodule
